// >>> bspc_pkg.sv
// constants, register map and field layout of the body speed and power take-off controller
package bspc_pkg;
	// clock and millisecond tick
	localparam int          CLK_HZ          = 250_000_000;
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          MS_PERIOD_NS    = 1_000_000;
	localparam int          TICK_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          TICK_W          = 18;
	// times in milliseconds
	localparam logic [11:0] TAP_MAX_MS      = 12'd200;
	localparam logic [6:0]  REPEAT_MS       = 7'd100;
	localparam logic [11:0] SPEED_EN_MS     = 12'd3500;
	localparam logic [11:0] READY_MS        = 12'd3000;
	localparam logic [11:0] PTO_EN_MS       = 12'd3000;
	localparam logic [11:0] RECALL_MAX_MS   = 12'd1000;
	localparam logic [11:0] STORE_MIN_MS    = 12'd2000;
	localparam logic [3:0]  DEBOUNCE_MS     = 4'd10;
	// switch input indices
	localparam int          NUM_IN          = 11;
	localparam int          IN_UP           = 0;
	localparam int          IN_DOWN         = 1;
	localparam int          IN_CANCEL       = 2;
	localparam int          IN_PRESET       = 3;
	localparam int          IN_PTO_REQ      = 4;
	localparam int          IN_CAB_OFF      = 5;
	localparam int          IN_SHUTDOWN     = 6;
	localparam int          IN_NEUTRAL      = 7;
	localparam int          IN_PARK         = 8;
	localparam int          IN_STOPPED      = 9;
	localparam int          IN_IGNITION     = 10;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STEP        = 8'h04;
	localparam logic [7:0]  OFS_LIMIT       = 8'h08;
	localparam logic [7:0]  OFS_PTO_THR     = 8'h0C;
	localparam logic [7:0]  OFS_PWM_FREQ    = 8'h10;
	localparam logic [7:0]  OFS_PRESET      = 8'h14;
	localparam logic [7:0]  OFS_STATUS      = 8'h18;
	// control register fields
	localparam int          CTRL_FINE       = 0;
	localparam int          CTRL_STORE_EN   = 1;
	localparam int          CTRL_SRC_CAN    = 2;
	localparam int          CTRL_NEED_NEUT  = 3;
	localparam int          CTRL_NEED_PARK  = 4;
	localparam int          CTRL_NEED_STOP  = 5;
	localparam int          CTRL_THR_ON     = 6;
	localparam int          CTRL_THR_ONOFF  = 7;
	localparam int          CTRL_PWM_SEL_LO = 8;
	localparam int          CTRL_W          = 10;
	// reset values
	localparam logic [9:0]  CTRL_RST        = 10'h238;
	localparam logic [23:0] STEP_RST        = 24'h0F0A32;
	localparam logic [31:0] LIMIT_RST       = 32'h0960_0258;
	localparam logic [31:0] PTO_THR_RST     = 32'h0316_0190;
	localparam logic [15:0] PRESET_RST      = 16'h0320;
	// pwm
	localparam logic [8:0]  PWM_FREQ_MIN    = 9'd100;
	localparam logic [8:0]  PWM_FREQ_MAX    = 9'd400;
	localparam logic [8:0]  PWM_FREQ_RST    = 9'd200;
	localparam longint      PWM_INC_PER_HZ  = (64'd1 << 40) / CLK_HZ;
	localparam logic [8:0]  PWM_DUTY_FLOOR  = 9'd26;
	localparam logic [8:0]  PWM_DUTY_SPAN   = 9'd231;
	localparam logic [1:0]  PWM_SEL_DEMAND  = 2'd0;
	localparam logic [1:0]  PWM_SEL_ACTUAL  = 2'd1;
	localparam logic [1:0]  PWM_SEL_LOAD    = 2'd2;
endpackage

// >>> bspc_core.sv
// body speed control, power take-off valve and torque pwm core with apb registers
// Functional notes
// [RQ1] speed-down press under 200 ms lowers setpoint once by tap step
// [RQ2] speed-down held past 200 ms lowers setpoint by hold step every 100 ms
// [RQ3] lowering stops at lower limit; on release setpoint takes current engine speed
// [RQ4] external pulse drivers should use about 100 ms high, 100 ms low
// [RQ5] speed-down ignored until 3.5 s after ignition on
// [RQ6] speed control runs only while cancel input asserted; opening drops to limit
// [RQ7] cancel held open keeps speed control off and refuses activation
// [RQ8] preset press of at most 1 s recalls preset speed
// [RQ9] press of at least 2 s stores setpoint when storing is enabled; the code stores only while speed control is active
// [RQ10] preset acts only on release, press length measured up to it
// [RQ11] cab off switch or shutdown condition also drops speed control
// [RQ12] enabled take-off preconditions are ANDed and checked at request arrival
// [RQ13] once energised the valve stays on though preconditions fail
// [RQ14] threshold-on mode energises above upper threshold and holds it
// [RQ15] on-off mode drops below lower, re-energises only if request and conditions hold
// [RQ16] request source is digital input or body CAN, the other ignored
// [RQ17] take-off requests accepted only 3 s after ignition on
// [RQ18] factory: all preconditions on, thresholds off, 790 and 400 rpm, digital
// [RQ19] take-off status output low while valve on, high otherwise
// [RQ20] pwm encodes demand torque, actual torque or engine load
// [RQ21] pwm frequency 100 to 400 Hz, factory load at 200 Hz
// [RQ22] duty is high time; zero maps 10 percent, full scale 100 percent
// [RQ23] ready output rises 3 s after ignition on
// [RQ24] speed-up mirrors speed-down, raising up to the upper limit
// [RQ25] switch inputs synchronised and debounced on the millisecond tick
// [RQ26] ignition off clears timers, setpoint state and valve
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module bspc_core
	import bspc_pkg::*;
#(
	parameter int TICK_CYCLES = bspc_pkg::TICK_CYCLES_DEF
)(
	input  wire logic                   pclk,            // system clock
	input  wire logic                   presetn,         // async reset, active low
	input  wire logic                   psel,            // apb select
	input  wire logic                   penable,         // apb access phase
	input  wire logic                   pwrite,          // apb write
	input  wire logic [7:0]             paddr,           // apb byte address
	input  wire logic [31:0]            pwdata,          // apb write data
	output logic      [31:0]            prdata,          // apb read data
	output logic                        pready,          // apb ready
	output logic                        pslverr,         // apb error
	input  wire logic [bspc_pkg::NUM_IN-1:0] switch_pins, // raw switch and condition inputs
	input  wire logic                   can_pto_req,     // body CAN take-off request
	input  wire logic [15:0]            engine_speed,    // actual engine speed, rpm
	input  wire logic [7:0]             demand_torque,   // driver demand torque, full scale 255
	input  wire logic [7:0]             actual_torque,   // actual engine torque
	input  wire logic [7:0]             engine_load,     // load at current speed
	output logic                        ready,           // service ready output
	output logic                        speed_ctrl_on,   // intermediate speed control active
	output logic      [15:0]            setpoint_rpm,    // nominal speed setpoint
	output logic                        pto_valve,       // take-off valve drive
	output logic                        pto_status_n,    // take-off status, low when valve on
	output logic                        torque_pwm_output // load or torque pwm
);
	import bspc_pkg::*;

	typedef struct packed {
		logic [NUM_IN-1:0]       sync1;
		logic [NUM_IN-1:0]       sync2;
		logic [NUM_IN-1:0]       deb;
		logic [NUM_IN-1:0][3:0]  dcnt;
		logic [TICK_W-1:0]       tick_cnt;
		logic                    tick;
		logic [11:0]             ign_ms;
		logic                    ready;
		logic [11:0]             up_ms;
		logic [11:0]             dn_ms;
		logic [11:0]             pre_ms;
		logic [6:0]              rep_ms;
		logic                    active;
		logic [15:0]             setpoint;
		logic [15:0]             preset;
		logic [CTRL_W-1:0]       ctrl;
		logic [23:0]             step;
		logic [31:0]             limit;
		logic [31:0]             thr;
		logic [8:0]              freq;
		logic                    req_prev;
		logic                    armed;
		logic                    valve;
		logic                    status_n;
		logic [39:0]             phase;
		logic                    pwm;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
	} bspc_state_type;

	bspc_state_type s_q;
	bspc_state_type s_d;

	function automatic logic [15:0] bspc_step_down(input logic [15:0] v, input logic [15:0] amt,
		input logic [15:0] lo);
		logic [16:0] floor_sum;
		floor_sum = {1'b0, lo} + {1'b0, amt};
		if ({1'b0, v} < floor_sum)
			return lo;
		return v - amt;
	endfunction

	function automatic logic [15:0] bspc_step_up(input logic [15:0] v, input logic [15:0] amt,
		input logic [15:0] hi);
		logic [16:0] sum;
		sum = {1'b0, v} + {1'b0, amt};
		if (sum > {1'b0, hi})
			return hi;
		return sum[15:0];
	endfunction

	logic [15:0] lo_lim;
	logic [15:0] hi_lim;
	logic [15:0] tap_amt;
	logic [15:0] hold_amt;
	logic [15:0] spd_clamped;
	logic [15:0] base;
	logic        sp_en;
	logic        pto_en;
	logic        up_now;
	logic        dn_now;
	logic        pre_now;
	logic        cond_ok;
	logic        req;
	logic        req_rise;
	logic        over_hi;
	logic        under_lo;
	logic [7:0]  pwm_val;
	logic [16:0] duty_prod;
	logic [8:0]  duty_thr;
	logic        wr_en;
	logic        rd_setup;

	always_comb
	begin
		s_d = s_q;
		lo_lim = s_q.limit[15:0];
		hi_lim = s_q.limit[31:16];
		tap_amt = {8'h00, s_q.ctrl[CTRL_FINE] ? s_q.step[15:8] : s_q.step[7:0]};
		hold_amt = {8'h00, s_q.step[23:16]};
		spd_clamped = engine_speed < lo_lim ? lo_lim : (engine_speed > hi_lim ? hi_lim : engine_speed);
		base = s_q.active ? s_q.setpoint : spd_clamped;

		// millisecond tick; debounce trades 10 ms of latency for immunity to contact bounce
		s_d.tick = 1'b0;
		if (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1))
		begin
			s_d.tick_cnt = '0;
			s_d.tick = 1'b1;
		end
		else
			s_d.tick_cnt = s_q.tick_cnt + 1'b1;
		s_d.sync1 = switch_pins;
		s_d.sync2 = s_q.sync1;
		for (int i = 0; i < NUM_IN; i++)
		begin
			if (s_q.tick)
			begin
				if (s_q.sync2[i] == s_q.deb[i])
					s_d.dcnt[i] = '0;
				else if (s_q.dcnt[i] == DEBOUNCE_MS - 4'd1)
				begin
					s_d.deb[i] = s_q.sync2[i]; // RQ25
					s_d.dcnt[i] = '0;
				end
				else
					s_d.dcnt[i] = s_q.dcnt[i] + 4'd1;
			end
		end

		// ignition time base
		if (!s_q.deb[IN_IGNITION])
			s_d.ign_ms = '0; // RQ26
		else if (s_q.tick && s_q.ign_ms != SPEED_EN_MS)
			s_d.ign_ms = s_q.ign_ms + 12'd1;
		s_d.ready = s_q.deb[IN_IGNITION] && s_q.ign_ms >= READY_MS; // RQ23
		sp_en = s_q.deb[IN_IGNITION] && s_q.ign_ms >= SPEED_EN_MS; // RQ5
		pto_en = s_q.deb[IN_IGNITION] && s_q.ign_ms >= PTO_EN_MS; // RQ17

		up_now = sp_en && s_q.deb[IN_UP];
		dn_now = sp_en && s_q.deb[IN_DOWN];
		pre_now = sp_en && s_q.deb[IN_PRESET];

		// press timers saturate so that very long holds stay long
		if (s_q.tick)
		begin
			if (up_now && s_q.up_ms != 12'hFFF)
				s_d.up_ms = s_q.up_ms + 12'd1;
			if (dn_now && s_q.dn_ms != 12'hFFF)
				s_d.dn_ms = s_q.dn_ms + 12'd1;
			if (pre_now && s_q.pre_ms != 12'hFFF)
				s_d.pre_ms = s_q.pre_ms + 12'd1; // RQ10
			if ((up_now && s_q.up_ms >= TAP_MAX_MS) || (dn_now && s_q.dn_ms >= TAP_MAX_MS))
				s_d.rep_ms = (s_q.rep_ms == REPEAT_MS - 7'd1) ? 7'd0 : s_q.rep_ms + 7'd1;
		end
		if (!up_now)
			s_d.up_ms = '0;
		if (!dn_now)
			s_d.dn_ms = '0;
		if (!pre_now)
			s_d.pre_ms = '0;
		if (!up_now && !dn_now)
			s_d.rep_ms = '0;

		// speed control setpoint; cancel and shutdown outrank every request
		if (!s_q.deb[IN_IGNITION] || !s_q.deb[IN_CANCEL])
		begin
			s_d.active = 1'b0; // RQ6 RQ7
			s_d.setpoint = lo_lim;
		end
		else if (s_q.deb[IN_CAB_OFF] || s_q.deb[IN_SHUTDOWN])
		begin
			s_d.active = 1'b0; // RQ11
			s_d.setpoint = lo_lim;
		end
		else if (s_q.pre_ms != '0 && !pre_now)
		begin
			if (s_q.pre_ms <= RECALL_MAX_MS)
			begin
				s_d.active = 1'b1; // RQ8
				s_d.setpoint = s_q.preset;
			end
			else if (s_q.pre_ms >= STORE_MIN_MS && s_q.ctrl[CTRL_STORE_EN] && s_q.active)
				s_d.preset = s_q.setpoint; // RQ9
		end
		else if (s_q.dn_ms != '0 && !dn_now)
		begin
			s_d.active = 1'b1;
			if (s_q.dn_ms < TAP_MAX_MS)
				s_d.setpoint = bspc_step_down(base, tap_amt, lo_lim); // RQ1
			else
				s_d.setpoint = spd_clamped; // RQ3
		end
		else if (s_q.up_ms != '0 && !up_now)
		begin
			s_d.active = 1'b1;
			if (s_q.up_ms < TAP_MAX_MS)
				s_d.setpoint = bspc_step_up(base, tap_amt, hi_lim); // RQ24
			else
				s_d.setpoint = spd_clamped; // RQ24
		end
		else if (s_q.tick && s_q.rep_ms == REPEAT_MS - 7'd1)
		begin
			s_d.active = 1'b1;
			if (dn_now)
				s_d.setpoint = bspc_step_down(base, hold_amt, lo_lim); // RQ2 RQ3
			else
				s_d.setpoint = bspc_step_up(base, hold_amt, hi_lim); // RQ24
		end

		// take-off valve
		req = pto_en && (s_q.ctrl[CTRL_SRC_CAN] ? can_pto_req : s_q.deb[IN_PTO_REQ]); // RQ16
		req_rise = req && !s_q.req_prev;
		cond_ok = (!s_q.ctrl[CTRL_NEED_NEUT] || s_q.deb[IN_NEUTRAL])
			&& (!s_q.ctrl[CTRL_NEED_PARK] || s_q.deb[IN_PARK])
			&& (!s_q.ctrl[CTRL_NEED_STOP] || s_q.deb[IN_STOPPED]); // RQ12
		over_hi = engine_speed > s_q.thr[31:16];
		under_lo = engine_speed < s_q.thr[15:0];
		s_d.req_prev = req;
		if (!req)
			s_d.armed = 1'b0;
		else if (req_rise && cond_ok)
			s_d.armed = 1'b1; // RQ12
		if (!s_q.deb[IN_IGNITION] || !req)
			s_d.valve = 1'b0; // RQ26
		else if (s_q.ctrl[CTRL_THR_ONOFF])
		begin
			if (s_q.valve && under_lo)
				s_d.valve = 1'b0; // RQ15
			else if (!s_q.valve && over_hi && (s_q.armed || req_rise) && cond_ok)
				s_d.valve = 1'b1; // RQ15
		end
		else if (s_q.ctrl[CTRL_THR_ON])
		begin
			if ((s_q.armed || (req_rise && cond_ok)) && over_hi)
				s_d.valve = 1'b1; // RQ14 RQ13
		end
		else if (req_rise && cond_ok)
			s_d.valve = 1'b1; // RQ13
		s_d.status_n = !s_d.valve; // RQ19
		if (!s_q.deb[IN_IGNITION])
		begin
			s_d.armed = 1'b0; // RQ26
			s_d.req_prev = 1'b0;
		end

		// pwm: phase accumulator avoids a divider for the programmable frequency
		case (s_q.ctrl[CTRL_PWM_SEL_LO +: 2])
			PWM_SEL_DEMAND: pwm_val = demand_torque; // RQ20
			PWM_SEL_ACTUAL: pwm_val = actual_torque;
			default:        pwm_val = engine_load;
		endcase
		duty_prod = 17'(pwm_val * PWM_DUTY_SPAN);
		duty_thr = PWM_DUTY_FLOOR + {1'b0, duty_prod[15:8]}; // RQ22
		s_d.phase = s_q.phase + 40'({31'd0, s_q.freq} * PWM_INC_PER_HZ); // RQ21
		s_d.pwm = {1'b0, s_q.phase[39:32]} < duty_thr;

		// apb slave, zero wait: data prepared in setup, ready in access
		wr_en = psel && penable && pwrite && s_q.pready;
		rd_setup = psel && !penable;
		s_d.pready = rd_setup;
		// error must not outlive the access cycle it qualifies
		s_d.pslverr = 1'b0;
		if (rd_setup)
		begin
			s_d.prdata = '0;
			if (paddr == OFS_CTRL)
				s_d.prdata = {22'd0, s_q.ctrl};
			else if (paddr == OFS_STEP)
				s_d.prdata = {8'd0, s_q.step};
			else if (paddr == OFS_LIMIT)
				s_d.prdata = s_q.limit;
			else if (paddr == OFS_PTO_THR)
				s_d.prdata = s_q.thr;
			else if (paddr == OFS_PWM_FREQ)
				s_d.prdata = {23'd0, s_q.freq};
			else if (paddr == OFS_PRESET)
				s_d.prdata = {16'd0, s_q.preset};
			else if (paddr == OFS_STATUS)
				s_d.prdata = {s_q.setpoint, 12'd0, s_q.ready, s_q.valve, s_q.armed, s_q.active};
			else
				s_d.pslverr = 1'b1;
		end
		if (wr_en)
		begin
			if (paddr == OFS_CTRL)
				s_d.ctrl = pwdata[CTRL_W-1:0];
			else if (paddr == OFS_STEP)
				s_d.step = pwdata[23:0];
			else if (paddr == OFS_LIMIT)
				s_d.limit = pwdata;
			else if (paddr == OFS_PTO_THR)
				s_d.thr = pwdata;
			else if (paddr == OFS_PWM_FREQ)
			begin
				if (pwdata[8:0] < PWM_FREQ_MIN || pwdata[31:9] != '0)
					s_d.freq = (pwdata[31:9] != '0) ? PWM_FREQ_MAX : PWM_FREQ_MIN;
				else if (pwdata[8:0] > PWM_FREQ_MAX)
					s_d.freq = PWM_FREQ_MAX; // RQ21
				else
					s_d.freq = pwdata[8:0];
			end
			else if (paddr == OFS_PRESET && !(s_q.pre_ms != '0 && !pre_now))
				s_d.preset = pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RST; // RQ18
			s_q.step <= STEP_RST;
			s_q.limit <= LIMIT_RST;
			s_q.thr <= PTO_THR_RST; // RQ18
			s_q.freq <= PWM_FREQ_RST;
			s_q.preset <= PRESET_RST;
			s_q.status_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign ready = s_q.ready;
	assign speed_ctrl_on = s_q.active;
	assign setpoint_rpm = s_q.setpoint;
	assign pto_valve = s_q.valve;
	assign pto_status_n = s_q.status_n;
	assign torque_pwm_output = s_q.pwm;
endmodule
`default_nettype wire

// >>> bspc_panel.sv
// switch panel model driving the controller's switch and condition pins
`timescale 1ns/10ps
`default_nettype none
module bspc_panel
	import bspc_pkg::*;
(
	input  wire logic                        ign,   // ignition key
	input  wire logic                        ready, // service ready feed
	input  wire logic [9:0]                  press, // contacts closed
	output logic      [bspc_pkg::NUM_IN-1:0] pins   // to switch_pins
);
	// contacts are fed from ready or ignition; an open contact reads low through its pull-down
	assign pins = {ign, press & {10{ready | ign}}};
endmodule
`default_nettype wire

// >>> bspc_core_asserts.sv
// port assertions for the body speed and take-off controller
`timescale 1ns/10ps
`default_nettype none
module bspc_core_asserts
	import bspc_pkg::*;
#(
	parameter int TICK_CYCLES = 250000
)(
	input wire logic                        pclk,          // clock
	input wire logic                        presetn,       // reset, active low
	input wire logic                        psel,          // apb select
	input wire logic                        penable,       // apb enable
	input wire logic                        pready,        // apb ready
	input wire logic                        pslverr,       // apb error
	input wire logic [bspc_pkg::NUM_IN-1:0] switch_pins,   // raw pins
	input wire logic                        ready,         // ready output
	input wire logic                        speed_ctrl_on, // speed control active
	input wire logic                        pto_valve,     // valve drive
	input wire logic                        pto_status_n   // valve status
);
	logic [31:0] ign_q;
	logic [31:0] ioff_q;
	logic [31:0] copen_q;
	// run lengths of raw pin levels; a 12 ms margin absorbs the debounce lag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ign_q <= '0;
			ioff_q <= '0;
			copen_q <= '0;
		end
		else
		begin
			ign_q <= switch_pins[IN_IGNITION] ? ign_q + 32'h1 : '0;
			ioff_q <= switch_pins[IN_IGNITION] ? '0 : ioff_q + 32'h1;
			copen_q <= switch_pins[IN_CANCEL] ? '0 : copen_q + 32'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	status_follows_a: assert property (pto_status_n == !pto_valve)
		else $error("status output disagrees with valve");
	ready_delay_a: assert property ($rose(ready) |-> ign_q >= 3000 * TICK_CYCLES)
		else $error("ready rose too early");
	pto_delay_a: assert property ($rose(pto_valve) |-> ign_q >= 3000 * TICK_CYCLES)
		else $error("valve energised too early");
	speed_delay_a: assert property ($rose(speed_ctrl_on) |-> ign_q >= 3500 * TICK_CYCLES)
		else $error("speed control active too early");
	cancel_off_a: assert property (copen_q > 12 * TICK_CYCLES |-> !speed_ctrl_on)
		else $error("speed control active with cancel open");
	ign_off_a: assert property (ioff_q > 12 * TICK_CYCLES |-> !pto_valve && !ready)
		else $error("outputs active with ignition off");
	apb_ready_a: assert property (psel && !penable |=> pready && penable)
		else $error("no zero wait answer");
	apb_err_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
bind bspc_core bspc_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_bspc_chk (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .switch_pins, .ready, .speed_ctrl_on, .pto_valve,
	.pto_status_n);
`default_nettype wire

// >>> tb.sv
// self-checking bench for the body speed and take-off controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	import bspc_pkg::*;
	localparam int T = 10;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pw;
	logic                  ign, can_pto_req, ready, speed_ctrl_on, pto_valve, pto_status_n;
	logic                  torque_pwm_output;
	logic [7:0]            paddr, engine_load;
	logic [31:0]           pwdata, prdata, rv;
	logic [9:0]            press;
	logic [15:0]           engine_speed, setpoint_rpm;
	logic [NUM_IN-1:0]     switch_pins;
	int                    n_fail, checked;
	bspc_core #(.TICK_CYCLES(T)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .switch_pins, .can_pto_req, .engine_speed,
		.demand_torque(8'h00), .actual_torque(8'h00), .engine_load, .ready, .speed_ctrl_on,
		.setpoint_rpm, .pto_valve, .pto_status_n, .torque_pwm_output);
	bspc_panel u_panel (.ign, .ready, .press, .pins(switch_pins));
	initial
	begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	task automatic complete_run();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'h1 && i < 50);
		if (i >= 50)
		begin
			n_fail++;
			complete_run();
		end
		rv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// idle edge so a following call never re-drives psel in the same step
		@(posedge pclk);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(nm, rv, e);
	endtask
	task automatic ms(input int n);
		repeat (n * T) @(posedge pclk);
	endtask
	// hold a contact closed, release it and let the debounce settle; n of 0 only releases
	task automatic tap(input int b, input int n);
		if (n > 0)
		begin
			press[b] <= 1'h1;
			ms(n);
		end
		press[b] <= 1'h0;
		ms(15);
	endtask
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		press = 10'h000;
		ign = 1'h0;
		can_pto_req = 1'h0;
		engine_speed = 16'h03E8;
		engine_load = 8'hFF;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk("status_n", pto_status_n, 32'h1);
		rd("ctrl", OFS_CTRL, 32'h238);
		rd("step", OFS_STEP, 32'h0F0A32);
		rd("limit", OFS_LIMIT, 32'h0960_0258);
		rd("thr", OFS_PTO_THR, 32'h0316_0190);
		rd("freq", OFS_PWM_FREQ, 32'hC8);
		rd("preset", OFS_PRESET, 32'h320);
		apb(1'h0, 8'h1C, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'h1, OFS_PWM_FREQ, 32'h1F4);
		rd("freq clamp", OFS_PWM_FREQ, 32'h190);
		$display("test registers done");
		ign <= 1'h1;
		press[IN_CANCEL] <= 1'h1;
		press[9:7] <= 3'h7;
		ms(1000);
		press[IN_PTO_REQ] <= 1'h1;
		ms(1900);
		chk("ready early", ready, 32'h0);
		chk("early req", pto_valve, 32'h0);
		tap(IN_DOWN, 100);
		ms(85);
		chk("ready", ready, 32'h1);
		chk("early down", speed_ctrl_on, 32'h0);
		tap(IN_PTO_REQ, 500);
		$display("test startup done");
		tap(IN_DOWN, 100);
		chk("tap down", setpoint_rpm, 32'h3B6);
		chk("active", speed_ctrl_on, 32'h1);
		tap(IN_UP, 100);
		chk("tap up", setpoint_rpm, 32'h3E8);
		apb(1'h1, OFS_CTRL, 32'h239);
		tap(IN_DOWN, 100);
		chk("fine tap", setpoint_rpm, 32'h3DE);
		// square-wave driver, 100 ms high and 100 ms low: every pulse is a tap
		repeat (2)
		begin
			tap(IN_DOWN, 100);
			ms(85);
		end
		chk("pulsed down", setpoint_rpm, 32'h3CA);
		press[IN_DOWN] <= 1'h1;
		ms(330);
		chk("hold step", setpoint_rpm, 32'h3BB);
		engine_speed <= 16'h01F4;
		ms(20);
		tap(IN_DOWN, 0);
		chk("hold release", setpoint_rpm, 32'h258);
		engine_speed <= 16'h03E8;
		press[IN_PRESET] <= 1'h1;
		ms(500);
		chk("no early recall", setpoint_rpm, 32'h258);
		tap(IN_PRESET, 0);
		chk("recall", setpoint_rpm, 32'h320);
		tap(IN_DOWN, 100);
		apb(1'h1, OFS_CTRL, 32'h23A);
		tap(IN_PRESET, 2100);
		rd("stored", OFS_PRESET, 32'h316);
		press[IN_CANCEL] <= 1'h0;
		ms(15);
		chk("cancel", speed_ctrl_on, 32'h0);
		chk("cancel spd", setpoint_rpm, 32'h258);
		tap(IN_UP, 100);
		chk("refused", speed_ctrl_on, 32'h0);
		press[IN_CANCEL] <= 1'h1;
		ms(15);
		for (int k = IN_CAB_OFF; k <= IN_SHUTDOWN; k++)
		begin
			tap(IN_UP, 100);
			chk("re-enable", speed_ctrl_on, 32'h1);
			press[k] <= 1'h1;
			ms(15);
			chk("drop", speed_ctrl_on, 32'h0);
			press[k] <= 1'h0;
			ms(15);
		end
		$display("test speed done");
		apb(1'h1, OFS_CTRL, 32'h238);
		press[IN_PTO_REQ] <= 1'h1;
		ms(15);
		chk("valve", pto_valve, 32'h1);
		chk("status", pto_status_n, 32'h0);
		press[IN_PARK] <= 1'h0;
		ms(15);
		chk("valve held", pto_valve, 32'h1);
		tap(IN_PTO_REQ, 0);
		press[IN_PTO_REQ] <= 1'h1;
		ms(15);
		chk("no park", pto_valve, 32'h0);
		press[IN_PTO_REQ] <= 1'h0;
		press[IN_PARK] <= 1'h1;
		can_pto_req <= 1'h1;
		ms(15);
		chk("can ignored", pto_valve, 32'h0);
		can_pto_req <= 1'h0;
		apb(1'h1, OFS_CTRL, 32'h23C);
		press[IN_PTO_REQ] <= 1'h1;
		ms(15);
		chk("pin ignored", pto_valve, 32'h0);
		can_pto_req <= 1'h1;
		ms(1);
		chk("can valve", pto_valve, 32'h1);
		can_pto_req <= 1'h0;
		tap(IN_PTO_REQ, 0);
		apb(1'h1, OFS_CTRL, 32'h278);
		engine_speed <= 16'h0316;
		press[IN_PTO_REQ] <= 1'h1;
		ms(15);
		chk("at upper", pto_valve, 32'h0);
		engine_speed <= 16'h0317;
		ms(1);
		chk("above upper", pto_valve, 32'h1);
		engine_speed <= 16'h012C;
		ms(1);
		chk("on held", pto_valve, 32'h1);
		apb(1'h1, OFS_CTRL, 32'h2B8);
		ms(1);
		chk("below lower", pto_valve, 32'h0);
		engine_speed <= 16'h0317;
		ms(1);
		chk("re-energise", pto_valve, 32'h1);
		tap(IN_PTO_REQ, 0);
		chk("req gone", pto_valve, 32'h0);
		$display("test take-off done");
		pw = 1'h1;
		repeat (200)
		begin
			@(posedge pclk);
			pw = pw & torque_pwm_output;
		end
		chk("pwm full", {31'h0, pw}, 32'h1);
		ign <= 1'h0;
		ms(15);
		chk("off ready", ready, 32'h0);
		chk("off speed", speed_ctrl_on, 32'h0);
		$display("test ignition done");
		complete_run();
	end
endmodule
`default_nettype wire
